//--- rtl/nrcps_consts.svh
`ifndef NRCPS_CONSTS_SVH
`define NRCPS_CONSTS_SVH
// Register byte offsets
`define NRCPS_OFF_STATUS    32'h0000_0004
`define NRCPS_OFF_RESET     32'h0000_000c
`define NRCPS_OFF_PROT      32'h0000_0024
`define NRCPS_OFF_CTRL      32'h0000_0040
// Control register fields
`define NRCPS_CTRL_KEEP_CLK 0
`define NRCPS_CTRL_KEEP_PWR 1
`define NRCPS_CTRL_IDLE_PD  2
`define NRCPS_CTRL_FRC_LSB  4
`define NRCPS_CTRL_FRC_MSB  7
// Reset request fields
`define NRCPS_RST_PRIV      0
`define NRCPS_RST_NSEC      1
// Block clock force bit positions
`define NRCPS_BLK_DMA       0
`define NRCPS_BLK_SBUF      1
// Reset values
`define NRCPS_CTRL_RST      8'h00
`define NRCPS_RSTREQ_RST    2'h0
// Timing: system reset held at least this many cycles (two), longer while hard reset input low
`define NRCPS_SYSRST_NS     20
`define NRCPS_CLK_NS        10
`define NRCPS_SYSRST_CYC    (`NRCPS_SYSRST_NS / `NRCPS_CLK_NS)
// AHB encodings
`define NRCPS_HSIZE_WORD    3'h2
`endif

//--- rtl/nrcps_pkg.sv
package nrcps_pkg;
    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DCLK = 6'h02,
        ST_DACK = 6'h04,
        ST_SRST = 6'h08,
        ST_CLR  = 6'h10,
        ST_UPD  = 6'h20
    } nrcps_state_e;
    // Block clock force vector
    typedef logic [3:0] nrcps_blk_t;
endpackage

//--- rtl/nrcps_top.sv
`timescale 1ns/1ps
`include "nrcps_consts.svh"
// Summary of operation
// - Hard reset input low starts hard sequence
// - Permitted reset register write starts soft reset
// - Permit if priv>=level and nonsec<=level
// - Any reset clears control register and memories
// - Soft resets start only inside this unit
// - Enable DMA clock, then signal soft reset
// - Wait DMA acknowledge before system reset
// - Core clock off, system reset within two
// - After release, clocks on, clear RAMs
// - Finally load new privilege and security
// - Clock free-running except reset or Q-gated
// - Clock may stop only when fully stopped
// - Keep-clock setting refuses clock-off requests
// - Power may drop only when fully stopped
// - Keep-power setting refuses power-down requests
// - One main clock gate ahead of blocks
// - Unit can force each block clock on
// - Idle controller requests slowdown or powerdown
// - Honour bus clock qualifier on transfers
// - One clock, one reset, gated clocks derived
// - Hard reset samples power-on privilege select
// - Hard reset samples power-on security select
// - Soft reset from a nonsecure requester never raises security level
// - Failed permission writes silently ignored
module nrcps_top (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset,
    input  wire logic                  i_clk_en,
    input  wire logic                  i_hsel,
    input  wire logic [31:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [2:0]            i_hsize,
    input  wire logic [3:0]            i_hprot,
    input  wire logic                  i_hnonsec,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic                  i_hready,
    output logic      [31:0]           o_hrdata,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    input  wire logic                  i_hard_reset_in_n,
    input  wire logic                  i_poweron_privilege_select,
    input  wire logic                  i_poweron_security_select,
    input  wire logic                  i_bus_clock_qualifier,
    input  wire logic                  i_dma_soft_ack,
    input  wire logic                  i_dma_clear_done,
    input  wire logic                  i_sbuf_clear_done,
    input  wire logic                  i_npu_stopped,
    input  wire logic                  i_central_controller_idle,
    input  wire logic [1:0]            i_qlp_req_n,
    output logic      [1:0]            o_qlp_accept_n,
    output logic      [1:0]            o_qlp_deny_n,
    output logic      [1:0]            o_qlp_active,
    output logic                       o_main_clk_en,
    output nrcps_pkg::nrcps_blk_t      o_blk_clk_force,
    output logic                       o_dma_soft_req,
    output logic                       o_sys_reset,
    output logic                       o_ram_clear_req,
    output logic                       o_clk_slow_req,
    output logic                       o_pwr_down_req,
    output logic                       o_current_privilege_level,
    output logic                       o_current_nonsecure_level,
    output nrcps_pkg::nrcps_state_e    o_seq_state
);
    import nrcps_pkg::*;

    // Word-aligned address match, used for every register
    function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] off);
        reg_hit = (addr[31:2] == off[31:2]);
    endfunction

    // Sequencer state and its bookkeeping
    nrcps_state_e state_reg;            // Current sequencer state
    nrcps_state_e state_next;           // Next sequencer state
    logic         hard_seq_reg;         // Sequence came from hard reset
    logic         hard_seq_next;
    logic [1:0]   hold_cnt_reg;         // System reset hold counter
    logic [1:0]   hold_cnt_next;

    // Register file
    logic [7:0]   ctrl_reg;             // Keep bits, idle mode, force bits
    logic [1:0]   rst_req_reg;          // Pending privilege / nonsecure
    logic         cur_priv_reg;         // Active privilege level
    logic         cur_nsec_reg;         // Active nonsecure level

    // AHB data-phase capture
    logic         dp_wr_reg;            // Write data phase pending
    logic [31:0]  dp_addr_reg;          // Address of that write
    logic         dp_nsec_reg;          // Requester's nonsecure bit

    // Bus decode
    wire          bus_phase  = i_hsel & i_htrans[1] & i_hready;
    wire          bus_word   = (i_hsize == `NRCPS_HSIZE_WORD);
    // Access check against active levels; same test for all registers
    wire          access_ok  = (i_hprot[1] >= cur_priv_reg) &&
                               (i_hnonsec <= cur_nsec_reg);
    wire          wr_take    = bus_phase & i_hwrite & bus_word & access_ok;
    wire          rd_take    = bus_phase & ~i_hwrite & access_ok;
    wire          hit_status = reg_hit(i_haddr, `NRCPS_OFF_STATUS);
    wire          hit_reset  = reg_hit(i_haddr, `NRCPS_OFF_RESET);
    wire          hit_prot   = reg_hit(i_haddr, `NRCPS_OFF_PROT);
    wire          hit_ctrl   = reg_hit(i_haddr, `NRCPS_OFF_CTRL);
    wire          dwr_reset  = dp_wr_reg & reg_hit(dp_addr_reg, `NRCPS_OFF_RESET);
    wire          dwr_ctrl   = dp_wr_reg & reg_hit(dp_addr_reg, `NRCPS_OFF_CTRL);
    // Requested levels; a nonsecure requester cannot ask for secure
    wire          new_priv   = i_hwdata[`NRCPS_RST_PRIV];
    wire          new_nsec   = i_hwdata[`NRCPS_RST_NSEC] | dp_nsec_reg;
    // Soft reset trigger exists only here, from the bus slave
    wire          seq_idle   = (state_reg == ST_IDLE);
    wire          soft_start = dwr_reset & seq_idle;
    // Device fully stopped and sequencer quiet
    wire          quiet      = i_npu_stopped & seq_idle;
    // Read mux; unmapped or refused reads return zero
    wire [31:0]   status_val = {20'h00000, o_qlp_accept_n, i_npu_stopped,
                                o_sys_reset, 2'h0, state_reg};
    wire [31:0]   rd_val     = !rd_take   ? 32'h0000_0000 :
                               hit_status ? status_val :
                               hit_reset  ? {30'h0, rst_req_reg} :
                               hit_prot   ? {30'h0, cur_nsec_reg, cur_priv_reg} :
                               hit_ctrl   ? {24'h000000, ctrl_reg} :
                               32'h0000_0000;

    // Sequencer next-state logic
    always_comb begin
        state_next    = state_reg;
        hard_seq_next = hard_seq_reg;
        hold_cnt_next = hold_cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                // Idle; wait for a permitted reset write
                if (soft_start) begin
                    state_next = ST_DCLK;
                end
            end
            ST_DCLK: begin
                // DMA clock forced on for one cycle first
                state_next = ST_DACK;
            end
            ST_DACK: begin
                // Ack only counts on a qualified bus cycle
                if (i_dma_soft_ack && i_bus_clock_qualifier) begin
                    state_next    = ST_SRST;
                    hold_cnt_next = 2'h0;
                end
            end
            ST_SRST: begin
                // Reset held a fixed time, longer while input low
                if (hold_cnt_reg == 2'(`NRCPS_SYSRST_CYC - 1)) begin
                    state_next = ST_CLR;
                end else begin
                    hold_cnt_next = hold_cnt_reg + 2'h1;
                end
            end
            ST_CLR: begin
                // Both RAM owners must report cleared
                if (i_dma_clear_done && i_sbuf_clear_done) begin
                    state_next = ST_UPD;
                end
            end
            ST_UPD: begin
                // Levels loaded this cycle
                state_next    = ST_IDLE;
                hard_seq_next = 1'b0;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Hard reset overrides everything and restarts the hold
        if (!i_hard_reset_in_n) begin
            state_next    = ST_SRST;
            hard_seq_next = 1'b1;
            hold_cnt_next = 2'h0;
        end
    end

    // Sequencer flops
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg    <= ST_SRST;
            hard_seq_reg <= 1'b1;
            hold_cnt_reg <= 2'h0;
        end else if (i_clk_en) begin
            state_reg    <= state_next;
            hard_seq_reg <= hard_seq_next;
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    // Bus data-phase capture and read data
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 32'h0000_0000;
            dp_nsec_reg <= 1'b0;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else if (i_clk_en) begin
            // Refused writes never reach a data phase
            dp_wr_reg   <= wr_take;
            dp_addr_reg <= i_haddr;
            dp_nsec_reg <= i_hnonsec;
            o_hrdata    <= rd_val;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    // Control register; cleared by every reset sequence
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || (i_clk_en && state_reg == ST_SRST)) begin
            ctrl_reg <= `NRCPS_CTRL_RST;
        end else if (i_clk_en && dwr_ctrl) begin
            ctrl_reg <= i_hwdata[7:0];
        end
    end

    // Pending levels; frozen once a sequence runs
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rst_req_reg <= `NRCPS_RSTREQ_RST;
        end else if (i_clk_en && soft_start) begin
            rst_req_reg <= {new_nsec, new_priv};
        end
    end

    // Active levels, loaded as the sequence's last step
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cur_priv_reg <= 1'b0;
            cur_nsec_reg <= 1'b0;
        end else if (i_clk_en && state_reg == ST_UPD) begin
            if (hard_seq_reg) begin
                // Straps sampled after release, never under reset
                cur_priv_reg <= i_poweron_privilege_select;
                cur_nsec_reg <= i_poweron_security_select;
            end else begin
                cur_priv_reg <= rst_req_reg[`NRCPS_RST_PRIV];
                cur_nsec_reg <= rst_req_reg[`NRCPS_RST_NSEC];
            end
        end
    end

    // Q-Channel slaves: index 0 clock, index 1 power
    logic [1:0] q_acc_next;             // Next accept, low active
    logic [1:0] q_deny_next;            // Next deny, low active
    logic [1:0] q_keep;                 // Keep-request settings
    assign q_keep = {ctrl_reg[`NRCPS_CTRL_KEEP_PWR], ctrl_reg[`NRCPS_CTRL_KEEP_CLK]};
    generate
        for (genvar gq = 0; gq < 2; gq++) begin : g_qch
            // Handshake idle: both answers high
            wire q_open  = o_qlp_accept_n[gq] & o_qlp_deny_n[gq];
            wire q_grant = quiet & ~q_keep[gq];
            wire q_new   = ~i_qlp_req_n[gq] & q_open;
            // Accept drops only with grant; deny when kept or busy
            assign q_acc_next[gq]  = q_new ? ~q_grant : (i_qlp_req_n[gq] | o_qlp_accept_n[gq]);
            assign q_deny_next[gq] = q_new ? q_grant : (i_qlp_req_n[gq] | o_qlp_deny_n[gq]);
        end
    endgenerate

    // One process owns both channels, so each output has a single driver
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_qlp_accept_n <= 2'h3;
            o_qlp_deny_n   <= 2'h3;
            o_qlp_active   <= 2'h3;
        end else if (i_clk_en) begin
            o_qlp_accept_n <= q_acc_next;
            o_qlp_deny_n   <= q_deny_next;
            o_qlp_active   <= ~{2{quiet}} | q_keep;
        end
    end
    // Clock gate and handshake outputs, from next state
    wire        nx_srst  = (state_next == ST_SRST);
    wire        nx_dma   = (state_next == ST_DCLK) || (state_next == ST_DACK);
    wire        nx_clr   = (state_next == ST_CLR);
    nrcps_blk_t seq_frc;                // Forces owned by the sequencer
    always_comb begin
        seq_frc = '0;
        seq_frc[`NRCPS_BLK_DMA]  = nx_dma | nx_clr;
        seq_frc[`NRCPS_BLK_SBUF] = nx_clr;
    end

    // All gate enables derive from the one input clock
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_main_clk_en   <= 1'b0;
            o_blk_clk_force <= '0;
            o_dma_soft_req  <= 1'b0;
            o_sys_reset     <= 1'b1;
            o_ram_clear_req <= 1'b0;
            o_seq_state     <= ST_SRST;
        end else if (i_clk_en) begin
            // Main gate sits ahead of the block gates
            o_main_clk_en   <= ~nx_srst & q_acc_next[0];
            o_blk_clk_force <= seq_frc |
                               ctrl_reg[`NRCPS_CTRL_FRC_MSB:`NRCPS_CTRL_FRC_LSB];
            o_dma_soft_req  <= (state_next == ST_DACK);
            o_sys_reset     <= nx_srst;
            o_ram_clear_req <= nx_clr;
            o_seq_state     <= state_next;
        end
    end

    // Level outputs of active settings and idle requests
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_current_privilege_level <= 1'b0;
            o_current_nonsecure_level <= 1'b0;
            o_clk_slow_req            <= 1'b0;
            o_pwr_down_req            <= 1'b0;
        end else if (i_clk_en) begin
            o_current_privilege_level <= cur_priv_reg;
            o_current_nonsecure_level <= cur_nsec_reg;
            // Request only while controller reports no event
            o_clk_slow_req <= i_central_controller_idle & ~ctrl_reg[`NRCPS_CTRL_IDLE_PD];
            o_pwr_down_req <= i_central_controller_idle & ctrl_reg[`NRCPS_CTRL_IDLE_PD];
        end
    end

    // Checks beside the logic
    property p_hard_start;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        !i_hard_reset_in_n |=> o_sys_reset && !o_main_clk_en;
    endproperty
    a_hard_start: assert property (p_hard_start) else $error("hard reset missed");

    property p_soft_refused;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (bus_phase && i_hwrite && hit_reset && !access_ok && seq_idle &&
         i_hard_reset_in_n) |=> ##1 (state_reg == ST_IDLE || !i_hard_reset_in_n);
    endproperty
    a_soft_refused: assert property (p_soft_refused) else $error("refused write reset");

    property p_soft_start;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (soft_start && i_hard_reset_in_n) |=> o_blk_clk_force[0] && !o_dma_soft_req
            ##1 (o_dma_soft_req || o_sys_reset);
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft order wrong");

    property p_wait_ack;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (state_reg == ST_DACK && !i_dma_soft_ack && i_hard_reset_in_n) |=> !o_sys_reset;
    endproperty
    a_wait_ack: assert property (p_wait_ack) else $error("reset before ack");

    property p_sysrst_len;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        ($rose(o_sys_reset) && i_hard_reset_in_n) |-> !o_main_clk_en
            ##1 (o_sys_reset || !$past(i_hard_reset_in_n));
    endproperty
    a_sysrst_len: assert property (p_sysrst_len) else $error("system reset too short");

    property p_clear_after;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        $fell(o_sys_reset) |-> o_ram_clear_req && o_blk_clk_force[0] && o_blk_clk_force[1];
    endproperty
    a_clear_after: assert property (p_clear_after) else $error("no RAM clear");

    property p_levels;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (state_reg == ST_UPD && !hard_seq_reg && i_hard_reset_in_n)
            |=> cur_nsec_reg == $past(rst_req_reg[1]) ##1
                o_current_nonsecure_level == $past(rst_req_reg[1], 2);
    endproperty
    a_levels: assert property (p_levels) else $error("levels not loaded");

    property p_clk_accept;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        $fell(o_qlp_accept_n[0]) |-> $past(quiet) && !$past(q_keep[0]) && !o_main_clk_en;
    endproperty
    a_clk_accept: assert property (p_clk_accept) else $error("bad clock accept");

    property p_pwr_keep;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (q_keep[1] && !i_qlp_req_n[1] && o_qlp_accept_n[1] && o_qlp_deny_n[1])
            |=> o_qlp_accept_n[1] && !o_qlp_deny_n[1];
    endproperty
    a_pwr_keep: assert property (p_pwr_keep) else $error("keep-power not denied");

    property p_busy_ignore;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (dwr_reset && !seq_idle) |=> $stable(rst_req_reg);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("busy write took");

    property p_idle_req;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        !i_central_controller_idle |=> !o_clk_slow_req && !o_pwr_down_req;
    endproperty
    a_idle_req: assert property (p_idle_req) else $error("idle request wrong");
endmodule

//--- tb/nrcps_far_model.sv
`timescale 1ns/1ps
// DMA and shared buffer side of the reset handshake
module nrcps_far_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_dma_soft_req,
    input  wire logic       i_ram_clear_req,
    output logic            o_dma_soft_ack,
    output logic            o_dma_clear_done,
    output logic            o_sbuf_clear_done
);
    logic [3:0] cnt_reg;    // Cycles since a request rose
    // Answers only while asked and after a set wait; slow settings stress the sequencer
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cnt_reg           <= 4'h0;
            o_dma_soft_ack    <= 1'b0;
            o_dma_clear_done  <= 1'b0;
            o_sbuf_clear_done <= 1'b0;
        end else begin
            cnt_reg           <= (i_dma_soft_req | i_ram_clear_req) ? cnt_reg + 4'h1 : 4'h0;
            o_dma_soft_ack    <= i_dma_soft_req && cnt_reg >= i_delay;
            o_dma_clear_done  <= i_ram_clear_req && cnt_reg >= i_delay;
            o_sbuf_clear_done <= i_ram_clear_req && cnt_reg >= i_delay + 4'h1;
        end
    end
endmodule

//--- tb/tb_nrcps_top.sv
`timescale 1ns/1ps
`include "nrcps_consts.svh"
module tb_nrcps_top;
    import nrcps_pkg::*;
    logic        i_clk_sys = 1'b0, i_reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, hnonsec = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0, qreq_n = 2'h3;
    logic [3:0]  hprot = 4'h0, dly = 4'h1;
    logic        hrst_n = 1'b1, qual = 1'b1, stopped = 1'b0, idle = 1'b0, cen = 1'b1;
    logic [31:0] o_hrdata;
    logic        o_hreadyout, o_hresp, o_main_clk_en, o_dma_soft_req, o_sys_reset;
    logic        o_ram_clear_req, o_clk_slow_req, o_pwr_down_req, ack, dclr, sclr, o_priv, o_nsec;
    logic [1:0]  o_acc_n, o_deny_n, o_active;
    nrcps_blk_t  o_blk_clk_force;
    nrcps_state_e o_seq_state;
    int          n_errors = 0, total_checks = 0;
    // Free-running 100 MHz clock
    always #5 i_clk_sys = ~i_clk_sys;
    nrcps_top i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_clk_en(cen), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(`NRCPS_HSIZE_WORD),
        .i_hprot(hprot), .i_hnonsec(hnonsec), .i_hwdata(hwdata), .i_hready(o_hreadyout),
        .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .i_hard_reset_in_n(hrst_n), .i_poweron_privilege_select(1'b1),
        .i_poweron_security_select(1'b0), .i_bus_clock_qualifier(qual), .i_dma_soft_ack(ack),
        .i_dma_clear_done(dclr), .i_sbuf_clear_done(sclr), .i_npu_stopped(stopped),
        .i_central_controller_idle(idle), .i_qlp_req_n(qreq_n), .o_qlp_accept_n(o_acc_n),
        .o_qlp_deny_n(o_deny_n), .o_qlp_active(o_active), .o_main_clk_en(o_main_clk_en),
        .o_blk_clk_force(o_blk_clk_force), .o_dma_soft_req(o_dma_soft_req),
        .o_sys_reset(o_sys_reset), .o_ram_clear_req(o_ram_clear_req),
        .o_clk_slow_req(o_clk_slow_req), .o_pwr_down_req(o_pwr_down_req),
        .o_current_privilege_level(o_priv), .o_current_nonsecure_level(o_nsec),
        .o_seq_state(o_seq_state));
    nrcps_far_model i_far (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_delay(dly),
        .i_dma_soft_req(o_dma_soft_req), .i_ram_clear_req(o_ram_clear_req),
        .o_dma_soft_ack(ack), .o_dma_clear_done(dclr), .o_sbuf_clear_done(sclr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic [31:0] a, d, input logic [3:0] p,
                       input logic ns, output logic [31:0] rd);
        @(posedge i_clk_sys);
        {hsel, htrans, haddr, hwrite, hprot, hnonsec} <= {1'b1, 2'h2, a, wr, p, ns};
        do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 80 && o_seq_state !== ST_IDLE; i++) @(posedge i_clk_sys);
        // Level outputs follow the load by one cycle
        repeat (2) @(posedge i_clk_sys);
    endtask
    task automatic t_boot();
        logic [31:0] r;
        wait_idle();
        chk({o_hreadyout, o_hresp, o_nsec, o_priv}, 4'h9);
        bus(1'b0, `NRCPS_OFF_PROT, 32'h0, 4'h2, 1'b0, r);
        chk(r, 32'h1);
        $display("boot test done");
    endtask
    // Clock or power handshake with given stop and keep settings
    task automatic t_q(input int ch, input logic st, input logic kp, input logic acc);
        logic [31:0] r;
        logic [1:0]  kb;
        kb = kp ? (2'h1 << ch) : 2'h0;
        stopped <= st;
        bus(1'b1, `NRCPS_OFF_CTRL, {30'h0, kb}, 4'h2, 1'b0, r);
        qreq_n[ch] <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        chk({o_acc_n[ch], o_deny_n[ch], o_active[ch]}, {!acc, acc, !acc});
        chk(o_main_clk_en, !(acc && ch == 0));
        qreq_n[ch] <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk({o_acc_n[ch], o_deny_n[ch]}, 2'h3);
    endtask
    task automatic t_idle();
        logic [31:0] r;
        idle <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, `NRCPS_OFF_CTRL, 32'ha0 | (m << 2), 4'h2, 1'b0, r);
            repeat (3) @(posedge i_clk_sys);
            chk(o_blk_clk_force, 4'ha);
            chk({o_clk_slow_req, o_pwr_down_req}, m ? 2'h1 : 2'h2);
        end
        cen  <= 1'b0;
        idle <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        chk({o_clk_slow_req, o_pwr_down_req}, 2'h1);
        cen  <= 1'b1;
        $display("idle test done");
    endtask
    task automatic t_denied();
        logic [31:0] r;
        bus(1'b0, `NRCPS_OFF_CTRL, 32'h0, 4'h0, 1'b1, r);
        chk(r, 32'h0);
        bus(1'b1, `NRCPS_OFF_RESET, 32'h0, 4'h0, 1'b1, r);
        repeat (4) @(posedge i_clk_sys);
        chk({o_seq_state, o_nsec, o_priv}, {ST_IDLE, 2'h1});
        $display("denied test done");
    endtask
    // Soft reset with a second request mid-sequence and a held qualifier
    task automatic t_soft(input logic [3:0] p, input logic ns, input logic [31:0] d,
                          input logic [1:0] lv);
        int srst;
        int acks;
        logic [31:0] r;
        srst = 0;
        acks = 0;
        qual <= 1'b0;
        bus(1'b1, `NRCPS_OFF_RESET, d, p, ns, r);
        bus(1'b1, `NRCPS_OFF_RESET, d ^ 32'h3, p, ns, r);
        repeat (80) begin
            @(posedge i_clk_sys);
            if (o_seq_state === ST_DACK) begin
                chk({o_blk_clk_force[0], o_dma_soft_req, o_sys_reset}, 3'h6);
                if (ack === 1'b1) acks++;
                if (acks == 3) qual <= 1'b1;
            end
            if (o_seq_state === ST_SRST) begin
                srst++;
                chk({o_sys_reset, o_main_clk_en}, 2'h2);
            end
            if (o_seq_state === ST_CLR) chk({o_ram_clear_req, o_blk_clk_force[1:0]}, 3'h7);
        end
        chk(srst, 2);
        chk(acks, 4);
        chk({o_seq_state, o_nsec, o_priv}, {ST_IDLE, lv});
        bus(1'b0, `NRCPS_OFF_CTRL, 32'h0, 4'h2, 1'b0, r);
        chk(r, 32'h0);
        $display("soft reset test done");
    endtask
    task automatic t_hard();
        logic [31:0] r;
        bus(1'b1, `NRCPS_OFF_CTRL, 32'h10, 4'h2, 1'b0, r);
        repeat (2) @(posedge i_clk_sys);
        chk(o_blk_clk_force, 4'h1);
        hrst_n <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        chk({o_sys_reset, o_seq_state}, {1'b1, ST_SRST});
        hrst_n <= 1'b1;
        wait_idle();
        chk({o_nsec, o_priv}, 2'h1);
        bus(1'b0, `NRCPS_OFF_CTRL, 32'h0, 4'h2, 1'b0, r);
        chk(r, 32'h0);
        $display("hard reset test done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        t_boot();
        for (int ch = 0; ch < 2; ch++) begin
            t_q(ch, 1'b1, 1'b0, 1'b1);
            t_q(ch, 1'b0, 1'b0, 1'b0);
            t_q(ch, 1'b1, 1'b1, 1'b0);
        end
        stopped <= 1'b0;
        $display("q-channel test done");
        t_idle();
        t_denied();
        t_soft(4'h2, 1'b0, 32'h2, 2'h2);
        dly <= 4'h6;
        t_soft(4'h0, 1'b1, 32'h0, 2'h2);
        t_hard();
        complete_run();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule
